// File: logic/activation_policy_power_negotiation.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "apn_params.svh"
module activation_policy_power_negotiation (
	input  wire logic                 aclk,              // 10 MHz clock
	input  wire logic                 aresetn,           // synchronous reset, active low
	input  wire logic [`ADDR_W-1:0]   awaddr,            // write address
	input  wire logic                 awvalid,           // write address valid
	output logic                      awready,           // write address ready
	input  wire logic [31:0]          wdata,             // write data
	input  wire logic [3:0]           wstrb,             // write byte enables
	input  wire logic                 wvalid,            // write data valid
	output logic                      wready,            // write data ready
	output logic [1:0]                bresp,             // write response
	output logic                      bvalid,            // write response valid
	input  wire logic                 bready,            // write response ready
	input  wire logic [`ADDR_W-1:0]   araddr,            // read address
	input  wire logic                 arvalid,           // read address valid
	output logic                      arready,           // read address ready
	output logic [31:0]               rdata,             // read data
	output logic [1:0]                rresp,             // read response
	output logic                      rvalid,            // read data valid
	input  wire logic                 rready,            // read data ready
	output apn_pkg::lc_state_t        lc_state,          // life-cycle state
	output logic                      activation_policy, // 1 = activate
	output logic                      negotiation_done,  // every slot has a set level
	output logic                      payload_power_en   // payload power switch
);
	import apn_pkg::*;

	apn_state_t s_r;
	apn_state_t s_nxt;
	logic       wr_go;
	logic       rd_go;
	logic       exec;
	logic       hdr_ok;
	logic [7:0] cmd;

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_strb

	// discrete form 1..21 levels, range form exactly 3
	function automatic logic [4:0] clamp_cnt(input logic rng, input logic [4:0] raw);
		if (rng) begin
			return `RNG_LVLS;
		end
		if (raw == 5'h00) begin
			return 5'h01;
		end
		if (raw > `MAX_LVLS) begin
			return `MAX_LVLS;
		end
		return raw;
	endfunction : clamp_cnt

	// advertised level = base entry plus option draw, saturating
	function automatic logic [7:0] adv_level(input logic [7:0] base, input logic [7:0] opt);
		logic [8:0] sum;
		sum = {1'b0, base} + {1'b0, opt};
		return sum[8] ? 8'hFF : sum[7:0];
	endfunction : adv_level

	function automatic logic slot_ok(input logic [2:0] slot);
		return slot < 3'(`NUM_SLOTS);
	endfunction : slot_ok

	function automatic logic pol_inapplicable(input lc_state_t lc, input logic act);
		case (lc)
			deactivation_requested_state,
			deactivation_in_progress_state,
			communication_lost_state:     return 1'b1;
			standby_state:                return !act;
			default:                      return 1'b0;
		endcase
	endfunction : pol_inapplicable

	// address and data are taken together; a pending response holds off the next request
	assign wr_go   = awvalid && wvalid && !s_r.bvalid;
	assign rd_go   = arvalid && !s_r.rvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = rd_go;
	assign exec    = wr_go && (awaddr == `ADDR_CMD);
	assign cmd     = wdata[7:0];
	assign hdr_ok  = (s_r.req[7:0] == `EXT_ID) && (s_r.req[15:8] == 8'h00);

	always_comb begin
		logic [2:0] slot;
		logic [4:0] idx;
		logic       act;
		logic       all_set;
		logic       all_pwr;
		slot    = 3'h0;
		idx     = 5'h00;
		act     = 1'b0;
		all_set = 1'b1;
		all_pwr = 1'b1;
		s_nxt   = s_r;
		if (bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (wr_go) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = `RESP_OKAY;
			case (awaddr)
				`ADDR_CMD: begin
					slot = s_r.req[18:16];
					act  = s_r.req[16];
					s_nxt.rsp = {16'h0000, `EXT_ID, `CC_OK};
					if (!hdr_ok) begin
						s_nxt.rsp[7:0] = `CC_BAD_FIELD;
					end else begin
						case (cmd)
							`CMD_SET_POL: begin
								if (pol_inapplicable(s_r.lc, act)) begin
									s_nxt.rsp[7:0] = `CC_BAD_STATE;
								end else begin
									s_nxt.policy = act;
									case (s_r.lc)
										insertion_pending_state: begin
											if (act) begin
												s_nxt.lc = s_r.lc;
											end else if (s_r.extract_ok) begin
												s_nxt.lc = inactive_state;
											end
										end
										activation_in_progress_state: begin
											if (act) begin
												s_nxt.lc = s_r.lc;
											end else if (s_r.extract_ok) begin
												s_nxt.lc = deactivation_in_progress_state;
											end
										end
										active_state: begin
											if (act) begin
												s_nxt.lc = s_r.lc;
											end else begin
												s_nxt.lc = deactivation_requested_state;
											end
										end
										standby_state: begin
											s_nxt.lc = active_state;
										end
										default: begin
										end
									endcase
								end
							end
							`CMD_GET_POL: begin
								s_nxt.rsp[23:16] = {7'h00, s_r.policy};
							end
							`CMD_GET_PWR: begin
								// answered in every state
								if (!slot_ok(slot) || s_r.req[20:19] > `PTYPE_DES || s_r.req[23:21] != 3'h0) begin
									s_nxt.rsp[7:0] = `CC_BAD_FIELD;
								end else begin
									idx = (s_r.req[20:19] == `PTYPE_CUR) ? s_r.slots[slot].cur
										: s_r.slots[slot].des;
									s_nxt.rsp[23:16] = {s_r.slots[slot].dyn, s_r.slots[slot].rng, 1'b0, idx};
									if (idx != 5'h00) begin
										s_nxt.rsp[31:24] = adv_level(s_r.tbl[slot][5'(idx - 5'h01)],
											s_r.slots[slot].opt);
									end
								end
							end
							`CMD_SET_PWR: begin
								idx = s_r.req[28:24];
								if (!slot_ok(slot) || idx > clamp_cnt(s_r.slots[slot].rng, s_r.slots[slot].cnt)) begin
									s_nxt.rsp[7:0] = `CC_RANGE;
								end else begin
									s_nxt.slots[slot].cur = idx;
									s_nxt.slots[slot].set = 1'b1;
								end
							end
							default: begin
								s_nxt.rsp[7:0] = `CC_BAD_CMD;
							end
						endcase
					end
				end
				`ADDR_REQ: begin
					s_nxt.req = merge_strb(s_r.req, wdata, wstrb);
				end
				`ADDR_LCCTL: begin
					s_nxt.extract_ok = wdata[0];
					s_nxt.pwr_req    = wdata[1];
					if (wdata[2] && s_r.lc == active_state) begin
						for (int i = 0; i < `NUM_SLOTS; i++) begin
							s_nxt.slots[i].set = 1'b0;
						end
					end
					if (wdata[3]) begin
						s_nxt.lc = lc_state_t'(wdata[6:4]);
					end
				end
				`ADDR_SEL: begin
					s_nxt.sel_slot = wdata[2:0];
					s_nxt.sel_idx  = wdata[12:8];
				end
				`ADDR_LVL: begin
					if (slot_ok(s_r.sel_slot) && s_r.sel_idx != 5'h00 && s_r.sel_idx <= `MAX_LVLS) begin
						s_nxt.tbl[s_r.sel_slot][5'(s_r.sel_idx - 5'h01)] = wdata[7:0];
					end else begin
						s_nxt.bresp = `RESP_SLVERR;
					end
				end
				`ADDR_SCFG: begin
					if (slot_ok(s_r.sel_slot)) begin
						slot = s_r.sel_slot;
						s_nxt.slots[slot].opt = wdata[31:24];
						s_nxt.slots[slot].dyn = wdata[17];
						s_nxt.slots[slot].rng = wdata[16];
						s_nxt.slots[slot].cnt = clamp_cnt(wdata[16], wdata[12:8]);
						idx = wdata[4:0];
						if (idx == 5'h00) begin
							idx = 5'h01;
						end
						if (idx > clamp_cnt(wdata[16], wdata[12:8])) begin
							idx = clamp_cnt(wdata[16], wdata[12:8]);
						end
						s_nxt.slots[slot].des = idx;
					end else begin
						s_nxt.bresp = `RESP_SLVERR;
					end
				end
				default: begin
					s_nxt.bresp = `RESP_SLVERR;
				end
			endcase
		end
		// fresh negotiation on entry to activation-in-progress
		if (s_nxt.lc == activation_in_progress_state && s_r.lc != activation_in_progress_state) begin
			for (int i = 0; i < `NUM_SLOTS; i++) begin
				s_nxt.slots[i].set = 1'b0;
			end
		end
		if (s_r.lc == deactivation_in_progress_state && s_nxt.lc == inactive_state) begin
			for (int i = 0; i < `NUM_SLOTS; i++) begin
				s_nxt.slots[i].cur = 5'h00;
				s_nxt.slots[i].set = 1'b0;
			end
		end
		for (int i = 0; i < `NUM_SLOTS; i++) begin
			all_set = all_set && s_nxt.slots[i].set;
			all_pwr = all_pwr && (s_nxt.slots[i].cur != 5'h00);
		end
		s_nxt.neg_done = all_set;
		s_nxt.pwr_en   = s_nxt.pwr_req && all_pwr && (s_nxt.lc == activation_in_progress_state
			|| s_nxt.lc == active_state);
		// read answer stands until rready is seen; a new read waits for it
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = `RESP_OKAY;
			s_nxt.rdata  = 32'h0000_0000;
			case (araddr)
				`ADDR_CMD:   s_nxt.rdata = 32'h0000_0000;
				`ADDR_REQ:   s_nxt.rdata = s_r.req;
				`ADDR_RSP:   s_nxt.rdata = s_r.rsp;
				`ADDR_STAT:  s_nxt.rdata = {24'h00_0000, s_r.pwr_en, s_r.neg_done, s_r.pwr_req,
					s_r.extract_ok, s_r.policy, s_r.lc};
				`ADDR_LCCTL: s_nxt.rdata = {25'h000_0000, s_r.lc, 2'b00, s_r.pwr_req, s_r.extract_ok};
				`ADDR_SEL:   s_nxt.rdata = {19'h0_0000, s_r.sel_idx, 5'h00, s_r.sel_slot};
				`ADDR_LVL: begin
					if (slot_ok(s_r.sel_slot) && s_r.sel_idx != 5'h00 && s_r.sel_idx <= `MAX_LVLS) begin
						s_nxt.rdata = {24'h00_0000, adv_level(s_r.tbl[s_r.sel_slot][5'(s_r.sel_idx - 5'h01)],
							s_r.slots[s_r.sel_slot].opt)};
					end else begin
						s_nxt.rresp = `RESP_SLVERR;
					end
				end
				`ADDR_SCFG: begin
					if (slot_ok(s_r.sel_slot)) begin
						slot = s_r.sel_slot;
						s_nxt.rdata = {s_r.slots[slot].opt, 6'h00, s_r.slots[slot].dyn, s_r.slots[slot].rng,
							3'h0, clamp_cnt(s_r.slots[slot].rng, s_r.slots[slot].cnt),
							s_r.slots[slot].set, 2'b00, s_r.slots[slot].des};
					end else begin
						s_nxt.rresp = `RESP_SLVERR;
					end
				end
				default:     s_nxt.rresp = `RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bvalid            = s_r.bvalid;
	assign bresp             = s_r.bresp;
	assign rvalid            = s_r.rvalid;
	assign rresp             = s_r.rresp;
	assign rdata             = s_r.rdata;
	assign lc_state          = s_r.lc;
	assign activation_policy = s_r.policy;
	assign negotiation_done  = s_r.neg_done;
	assign payload_power_en  = s_r.pwr_en;

	// checks
	logic pol_go;
	logic all_granted;
	assign pol_go      = exec && hdr_ok && cmd == `CMD_SET_POL;
	assign all_granted = (s_r.slots[0].cur != 5'h00) && (s_r.slots[1].cur != 5'h00);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_INSERT_ACT: assert property (pol_go && s_r.req[16] && s_r.lc == insertion_pending_state
		|=> lc_state == insertion_pending_state && activation_policy) else $error("insertion pending moved");
	AST_PROG_DEACT: assert property (pol_go && !s_r.req[16] && s_r.lc == activation_in_progress_state
		&& s_r.extract_ok |=> lc_state == deactivation_in_progress_state) else $error("no move to deact");
	AST_PROG_ACT: assert property (pol_go && s_r.req[16] && s_r.lc == activation_in_progress_state
		|=> $stable(lc_state)) else $error("activation in progress moved");
	AST_ACTIVE_DEACT: assert property (pol_go && !s_r.req[16] && s_r.lc == active_state
		|=> lc_state == deactivation_requested_state && !activation_policy) else $error("no deact request");
	AST_ACTIVE_ACT: assert property (pol_go && s_r.req[16] && s_r.lc == active_state
		|=> lc_state == active_state) else $error("active left");
	AST_STANDBY_ACT: assert property (pol_go && s_r.req[16] && s_r.lc == standby_state
		|=> lc_state == active_state ##1 lc_state == active_state) else $error("standby not active");
	AST_BAD_STATE: assert property (pol_go && pol_inapplicable(s_r.lc, s_r.req[16])
		|=> s_r.rsp[7:0] == `CC_BAD_STATE && $stable(lc_state) && $stable(activation_policy))
		else $error("inapplicable not refused");
	AST_EXT_ID: assert property (exec |=> s_r.rsp[15:8] == `EXT_ID) else $error("bad id");
	AST_GET_POL: assert property (exec && hdr_ok && cmd == `CMD_GET_POL
		|=> $stable(lc_state) && $stable(activation_policy) && s_r.rsp[16] == activation_policy)
		else $error("get policy disturbed");
	AST_PWR_GRANT: assert property (payload_power_en |-> all_granted) else $error("power w/o grant");
	AST_CNT_RANGE: assert property (clamp_cnt(s_r.slots[0].rng, s_r.slots[0].cnt) >= 5'h01
		&& clamp_cnt(s_r.slots[0].rng, s_r.slots[0].cnt) <= `MAX_LVLS) else $error("count out of range");
	AST_DONE: assert property (negotiation_done |-> s_r.slots[0].set && s_r.slots[1].set)
		else $error("done too early");
	AST_RESERVED_POL: assert property (pol_go && !pol_inapplicable(s_r.lc, s_r.req[16])
		|=> activation_policy == $past(s_r.req[16])) else $error("policy bit misread");
	AST_REFUSED_FIELD: assert property (exec && !hdr_ok
		|=> s_r.rsp[7:0] == `CC_BAD_FIELD && $stable(lc_state) && $stable(activation_policy))
		else $error("bad header taken");
	AST_RECLAIM: assert property (lc_state == deactivation_in_progress_state ##1 lc_state == inactive_state
		|-> s_r.slots[0].cur == 5'h00 && s_r.slots[1].cur == 5'h00) else $error("budget kept");
	AST_RENEG: assert property (wr_go && awaddr == `ADDR_LCCTL && wdata[2] && s_r.lc == active_state
		|=> !negotiation_done) else $error("renegotiation not started");
	AST_ENTRY_CLEAR: assert property (lc_state != activation_in_progress_state
		##1 lc_state == activation_in_progress_state |-> !negotiation_done) else $error("stale negotiation");
	AST_POL_RSP: assert property (exec && hdr_ok && cmd == `CMD_GET_POL
		|=> s_r.rsp[7:0] == `CC_OK && s_r.rsp[23:17] == 7'h00) else $error("policy answer malformed");
	AST_SET_RANGE: assert property (exec && hdr_ok && cmd == `CMD_SET_PWR && s_r.req[18:16] == 3'h1
		&& s_r.req[28:24] > clamp_cnt(s_r.slots[1].rng, s_r.slots[1].cnt)
		|=> s_r.rsp[7:0] == `CC_RANGE && $stable(s_r.slots[1].cur)) else $error("level beyond count granted");

	COV_STANDBY_ACT: cover property (pol_go && s_r.lc == standby_state ##1 lc_state == active_state);
	COV_REFUSED: cover property (pol_go ##1 s_r.rsp[7:0] == `CC_BAD_STATE);
	COV_NEG_DONE: cover property (!negotiation_done ##1 negotiation_done);
	COV_POWER_ON: cover property (!payload_power_en ##1 payload_power_en);
	COV_RENEG: cover property (wr_go && awaddr == `ADDR_LCCTL && wdata[2] && s_r.lc == active_state);
endmodule : activation_policy_power_negotiation
`default_nettype wire

// File: include/apn_params.svh
// Operation
// - Activate in insertion-pending leaves the life-cycle state unchanged.
// - Deactivate in activation-in-progress moves to deactivation-in-progress if extraction allowed.
// - Activate in activation-in-progress causes no transition.
// - Deactivate in active moves unconditionally to deactivation-requested.
// - Activate in active keeps the blade active.
// - Set-policy is inapplicable in requested, in-progress-off, comm-lost; Deactivate in standby.
// - Activate in standby moves directly to active.
// - Inapplicable policy command answers D5h and changes nothing.
// - Policy value byte uses bit 0 only; bits 7 to 1 reserved.
// - Requests must carry identifier 02h; responses always carry 02h.
// - Get-policy answers completion, identifier, then policy flag in byte 3 bit 0.
// - Get-policy changes neither policy flag nor life-cycle state.
// - Payload power stays off unless a non-zero budget was granted.
// - Discrete form advertises one to twenty-one levels per slot.
// - Range form advertises exactly three levels: minimum, desired, maximum.
// - From activation-in-progress on, power queries are answered at any time.
// - Advertised levels include base hardware plus attached options drawing slot power.
// - Each slot keeps its own supported, desired and current levels.
// - Negotiation completes only once every occupied slot has a set level.
// - In active state either party may start renegotiation.
// - Power query byte 3: bits 4:3 power type, bits 2:0 slot offset.
`ifndef APN_PARAMS_SVH
`define APN_PARAMS_SVH
`define ADDR_W       8
`define ADDR_CMD     8'h00
`define ADDR_REQ     8'h04
`define ADDR_RSP     8'h08
`define ADDR_STAT    8'h0C
`define ADDR_LCCTL   8'h10
`define ADDR_SEL     8'h14
`define ADDR_LVL     8'h18
`define ADDR_SCFG    8'h1C
`define CMD_SET_POL  8'h01
`define CMD_GET_POL  8'h02
`define CMD_GET_PWR  8'h03
`define CMD_SET_PWR  8'h04
`define EXT_ID       8'h02
`define CC_OK        8'h00
`define CC_BAD_CMD   8'hC1
`define CC_RANGE     8'hC9
`define CC_BAD_FIELD 8'hCC
`define CC_BAD_STATE 8'hD5
`define PTYPE_CUR    2'h0
`define PTYPE_DES    2'h1
`define NUM_SLOTS    2
`define MAX_LVLS     5'h15
`define RNG_LVLS     5'h03
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// File: include/apn_pkg.sv
`include "apn_params.svh"
package apn_pkg;
	typedef enum logic [2:0] {
		inactive_state,
		insertion_pending_state,
		activation_in_progress_state,
		active_state,
		deactivation_requested_state,
		deactivation_in_progress_state,
		communication_lost_state,
		standby_state
	} lc_state_t;

	typedef struct packed {
		logic [7:0] opt;     // option/mezzanine draw added to every level
		logic       dyn;
		logic       rng;
		logic [4:0] cnt;
		logic [4:0] des;
		logic [4:0] cur;
		logic       set;
	} slot_cfg_t;

	typedef struct packed {
		lc_state_t                                    lc;
		logic                                         policy;
		logic                                         extract_ok;
		logic                                         pwr_req;
		logic                                         pwr_en;
		logic                                         neg_done;
		logic [2:0]                                   sel_slot;
		logic [4:0]                                   sel_idx;
		logic [31:0]                                  req;
		logic [31:0]                                  rsp;
		slot_cfg_t [`NUM_SLOTS-1:0]                   slots;
		logic [`NUM_SLOTS-1:0][`MAX_LVLS-1:0][7:0]    tbl;
		logic                                         bvalid;
		logic [1:0]                                   bresp;
		logic                                         rvalid;
		logic [1:0]                                   rresp;
		logic [31:0]                                  rdata;
	} apn_state_t;
endpackage : apn_pkg

// File: verif/chassis_mgr_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "apn_params.svh"
module chassis_mgr_model (
	input  wire logic          aclk,    // bus clock
	output logic [`ADDR_W-1:0] awaddr,  // write address
	output logic               awvalid, // write address valid
	input  wire logic          awready, // write address ready
	output logic [31:0]        wdata,   // write data
	output logic [3:0]         wstrb,   // byte enables
	output logic               wvalid,  // write data valid
	input  wire logic          wready,  // write data ready
	input  wire logic [1:0]    bresp,   // write response
	input  wire logic          bvalid,  // write response valid
	output logic               bready,  // write response ready
	output logic [`ADDR_W-1:0] araddr,  // read address
	output logic               arvalid, // read address valid
	input  wire logic          arready, // read address ready
	input  wire logic [31:0]   rdata,   // read data
	input  wire logic [1:0]    rresp,   // read response
	input  wire logic          rvalid,  // read data valid
	output logic               rready   // read data ready
);
	localparam int LIMIT = 40;
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// a wait that runs out ends the run as a failure
	task automatic hang_check(input int n);
		if (n >= LIMIT) begin
			tb.n_errors++;
			tb.test_done();
		end
	endtask : hang_check
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r,
		input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// ready and valid are settled mid-cycle; the transfer happens at the next rising edge
		do begin
			@(negedge aclk);
			n++;
		end while ((awready & wready) !== 1'b1 && n < LIMIT);
		@(posedge aclk);
		// released address and data lines show the inverse, never the stale value
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		awaddr <= ~a;
		wdata <= ~d;
		do begin
			@(negedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < LIMIT);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
		hang_check(n);
	endtask : wr
	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (arready !== 1'b1 && n < LIMIT);
		@(posedge aclk);
		arvalid <= 1'b0;
		araddr <= ~a;
		do begin
			@(negedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < LIMIT);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
		hang_check(n);
	endtask : rd
	task automatic msg_raw(input logic [31:0] req, input logic [7:0] code, output logic [31:0] rsp);
		logic [1:0] r;
		wr(`ADDR_REQ, req, r);
		wr(`ADDR_CMD, {24'h00_0000, code}, r);
		rd(`ADDR_RSP, rsp, r);
	endtask : msg_raw
	task automatic msg(input logic [7:0] code, input logic [7:0] b3, input logic [7:0] b4,
		output logic [31:0] rsp);
		msg_raw({b4, b3, 8'h00, `EXT_ID}, code, rsp);
	endtask : msg
	// query every slot first, then grant or refuse each one
	task automatic negotiate(input logic [1:0] grant, output logic [31:0] rsp);
		logic [4:0] des [`NUM_SLOTS];
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			msg(`CMD_GET_PWR, {3'h0, `PTYPE_DES, 3'(s)}, 8'h00, rsp);
			des[s] = rsp[20:16];
		end
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			msg(`CMD_SET_PWR, 8'(s), grant[s] ? {3'h0, des[s]} : 8'h00, rsp);
		end
	endtask : negotiate
endmodule : chassis_mgr_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "apn_params.svh"
`define CHK(g, e) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb;
	import apn_pkg::*;
	logic               aclk = 1'b0;
	logic               aresetn = 1'b0;
	logic [`ADDR_W-1:0] awaddr, araddr;
	logic               awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0]        wdata, rdata, rsp;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp, r;
	lc_state_t          lc_state, ns;
	logic               activation_policy, negotiation_done, payload_power_en, ep;
	logic [7:0]         cc;
	logic [15:0]        eq [2] = '{16'h5005, 16'h30C2};
	logic [31:0]        bad [2] = '{32'h0000_0003, 32'h0000_0102};
	logic [7:0]         bq [3] = '{8'h10, 8'h0A, 8'h28};
	int                 n_errors = 0;
	int                 check_count = 0;
	always #50 aclk = ~aclk;
	chassis_mgr_model i_cm (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	activation_policy_power_negotiation i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .lc_state(lc_state), .activation_policy(activation_policy),
		.negotiation_done(negotiation_done), .payload_power_en(payload_power_en));
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// force the life-cycle state, with payload request and extraction flags
	task automatic goto(input logic [2:0] s, input logic p, input logic e);
		i_cm.wr(`ADDR_LCCTL, {25'h0, s, 1'b1, 1'b0, p, e}, r);
	endtask : goto
	initial begin
		ep = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK({lc_state, activation_policy}, {inactive_state, 1'b0})
		i_cm.rd(`ADDR_STAT, rsp, r);
		`CHK(rsp, 32'h0000_0000)
		i_cm.rd(8'h20, rsp, r);
		`CHK(r, `RESP_SLVERR)
		i_cm.wr(8'h24, 32'hFFFF_FFFF, r);
		`CHK(r, `RESP_SLVERR)
		i_cm.wr(`ADDR_REQ, 32'h1234_5678, r);
		i_cm.wr(`ADDR_REQ, 32'hABCD_EF01, r, 4'h5);
		i_cm.rd(`ADDR_REQ, rsp, r);
		`CHK(rsp, 32'h12CD_5601)
		for (int e = 0; e < 2; e++) begin
			for (int s = 0; s < 8; s++) begin
				for (int v = 0; v < 2; v++) begin
					goto(3'(s), 1'b0, 1'(e));
					i_cm.msg(`CMD_SET_POL, v ? 8'hFF : 8'hFE, 8'h00, rsp);
					ns = lc_state_t'(s);
					cc = `CC_OK;
					case (s)
						1: if (v == 0 && e == 1) ns = inactive_state;
						2: if (v == 0 && e == 1) ns = deactivation_in_progress_state;
						3: if (v == 0) ns = deactivation_requested_state;
						4, 5, 6: cc = `CC_BAD_STATE;
						7: begin
							if (v == 1) ns = active_state;
							else cc = `CC_BAD_STATE;
						end
						default: ;
					endcase
					if (cc == `CC_OK) ep = 1'(v);
					`CHK(rsp[15:0], {`EXT_ID, cc})
					`CHK(lc_state, ns)
					`CHK(activation_policy, ep)
				end
			end
		end
		i_cm.msg(`CMD_GET_POL, 8'h00, 8'h00, rsp);
		`CHK({rsp[23:16], rsp[15:0]}, {7'h00, ep, `EXT_ID, `CC_OK})
		`CHK({lc_state, activation_policy}, {active_state, ep})
		foreach (bad[i]) begin
			i_cm.msg_raw(bad[i], `CMD_SET_POL, rsp);
			`CHK({lc_state, rsp[15:0]}, {active_state, `EXT_ID, `CC_BAD_FIELD})
		end
		i_cm.msg(8'h09, 8'h00, 8'h00, rsp);
		`CHK(rsp[15:0], {`EXT_ID, `CC_BAD_CMD})
		goto(3'd2, 1'b1, 1'b0);
		i_cm.wr(`ADDR_SEL, 32'h0000_0500, r);
		i_cm.wr(`ADDR_SCFG, 32'h1000_1F05, r);
		i_cm.wr(`ADDR_LVL, 32'h0000_0040, r);
		i_cm.rd(`ADDR_SCFG, rsp, r);
		`CHK(rsp, 32'h1000_1505)
		i_cm.rd(`ADDR_LVL, rsp, r);
		`CHK(rsp[7:0], 8'h50)
		i_cm.wr(`ADDR_SEL, 32'h0000_0201, r);
		i_cm.wr(`ADDR_SCFG, 32'h0003_0A02, r);
		i_cm.wr(`ADDR_LVL, 32'h0000_0030, r);
		i_cm.rd(`ADDR_SCFG, rsp, r);
		`CHK(rsp, 32'h0003_0302)
		i_cm.wr(`ADDR_SEL, 32'h0000_1600, r);
		i_cm.wr(`ADDR_LVL, 32'h0000_0011, r);
		`CHK(r, `RESP_SLVERR)
		for (int s = 0; s < 2; s++) begin
			i_cm.msg(`CMD_GET_PWR, {3'h0, `PTYPE_DES, 3'(s)}, 8'h00, rsp);
			`CHK(rsp[31:16], eq[s])
		end
		i_cm.msg(`CMD_SET_PWR, 8'h00, 8'h05, rsp);
		`CHK({negotiation_done, payload_power_en}, 2'b00)
		i_cm.msg(`CMD_SET_PWR, 8'h01, 8'h04, rsp);
		`CHK(rsp[7:0], `CC_RANGE)
		i_cm.msg(`CMD_SET_PWR, 8'h01, 8'h00, rsp);
		`CHK({negotiation_done, payload_power_en}, 2'b10)
		i_cm.msg(`CMD_SET_PWR, 8'h01, 8'h02, rsp);
		`CHK({negotiation_done, payload_power_en}, 2'b11)
		i_cm.msg(`CMD_GET_PWR, {3'h0, `PTYPE_CUR, 3'h0}, 8'h00, rsp);
		`CHK(rsp[31:16], 16'h5005)
		foreach (bq[i]) begin
			i_cm.msg(`CMD_GET_PWR, bq[i], 8'h00, rsp);
			`CHK(rsp[7:0], `CC_BAD_FIELD)
		end
		goto(3'd3, 1'b1, 1'b0);
		i_cm.wr(`ADDR_LCCTL, 32'h0000_0006, r);
		`CHK({negotiation_done, payload_power_en}, 2'b01)
		i_cm.negotiate(2'b11, rsp);
		`CHK({negotiation_done, payload_power_en}, 2'b11)
		goto(3'd5, 1'b1, 1'b0);
		goto(3'd0, 1'b1, 1'b0);
		i_cm.msg(`CMD_GET_PWR, {3'h0, `PTYPE_CUR, 3'h1}, 8'h00, rsp);
		`CHK({payload_power_en, rsp[20:16], rsp[31:24]}, 14'h0000)
		test_done();
	end
endmodule : tb
`default_nettype wire
